// ---- dios_defines.vh ----
// Contract
// - high input level means logic one
// - open input reads as low
// - fixed debounce of one to two cycles
// - inputs offered true, inverted and as word
// - simulation value may replace pin level
// - output source chosen by configuration
// - per-output inversion before the pin
// - output state readable as bit and word
// - bidir pin configurable as input or output
// - six bidir inputs latch with no delay
// - io sampling interval set by configuration
// - signed 14-bit analog input with offset, scale, smoothing
// - analog input inversion, abs, noise, simulation, enable
// - 12-bit analog output code, characteristic, readback
`ifndef DIOS_DEFINES_VH
`define DIOS_DEFINES_VH
`define DIOS_NUM_DI 8
`define DIOS_NUM_BD 8
`define DIOS_NUM_FAST 6
`define DIOS_NUM_DO 4
`define DIOS_NUM_SRC 16
`define DIOS_SRC_W 4
`define DIOS_AI_W 14
`define DIOS_AO_W 12
`define DIOS_CNT_W 16
`define DIOS_SMOOTH_W 4
`define DIOS_CNT_ZERO 16'h0000
`define DIOS_CNT_ONE 16'h0001
`endif

// ---- dios_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dios_defines.vh"
module dios_top (
    input wire clk_i, // 125 MHz cycle clock
    input wire reset_i, // async reset, active high
    input wire [15:0] controller_cycle_setting_i, // clocks per controller cycle minus one
    input wire [15:0] io_sample_time_setting_i, // clocks per io sample minus one
    input wire [7:0] digital_in_pin_i, // digital input pins, pulled low when open
    input wire [7:0] di_sim_en_i, // per-input simulation enable
    input wire [7:0] di_sim_val_i, // per-input simulation value
    output reg [7:0] di_true_o, // conditioned inputs
    output reg [7:0] di_inv_o, // conditioned inputs, complemented
    output reg [15:0] di_word_o, // word: bidir inputs high byte, inputs low byte
    input wire [15:0] do_src_bits_i, // candidate output sources
    input wire [15:0] do_src_sel_i, // 4-bit source select per output
    input wire [3:0] do_invert_i, // per-output inversion
    output reg [3:0] digital_out_pin_o, // digital output pins
    output reg [3:0] do_state_o, // output state readback
    output reg [15:0] do_word_o, // outputs and bidir outputs as word
    input wire [7:0] bidir_pin_i, // bidir pin level
    output reg [7:0] bidir_pin_o, // bidir pin drive value
    output reg [7:0] bidir_pin_oe_o, // bidir drive enable, high drives
    input wire [7:0] bd_dir_out_i, // 1 = bidir used as output
    input wire [7:0] bd_sim_en_i, // bidir input simulation enable
    input wire [7:0] bd_sim_val_i, // bidir input simulation value
    input wire [31:0] bd_src_sel_i, // 4-bit source select per bidir
    input wire [7:0] bd_invert_i, // bidir output inversion
    output reg [7:0] bd_in_true_o, // conditioned bidir inputs
    output reg [7:0] bd_in_inv_o, // conditioned bidir inputs, complemented
    input wire [5:0] bd_meas_arm_i, // arm capture on fast bidir inputs
    output reg [5:0] bd_meas_val_o, // captured level on edge
    output reg [5:0] bd_meas_done_o, // capture taken, sticky while armed, cleared when arm drops
    input wire [13:0] analog_in_channel_i, // signed 14-bit converter code
    input wire ai_valid_i, // new converter code pulse
    input wire [13:0] ai_offset_i, // signed offset
    input wire [15:0] ai_scale_i, // signed gain, 1.0 = 16'h0100
    input wire [3:0] ai_smooth_i, // smoothing shift
    input wire [13:0] analog_noise_suppress_setting_i, // dead band around last value
    input wire ai_invert_i, // invert sample
    input wire ai_abs_i, // absolute value
    input wire ai_enable_i, // enable gate
    input wire ai_sim_en_i, // simulation enable
    input wire [13:0] ai_sim_val_i, // simulation code
    output reg [13:0] ai_value_o, // conditioned analog value
    input wire [13:0] ao_setpoint_i, // signed setpoint
    input wire ao_abs_i, // absolute value
    input wire ao_invert_i, // invert
    input wire [3:0] ao_smooth_i, // smoothing shift
    input wire [13:0] ao_x1_i, // characteristic point 1 input
    input wire [13:0] ao_y1_i, // characteristic point 1 output
    input wire [15:0] ao_slope_i, // characteristic slope, 1.0 = 16'h0100
    output reg [11:0] analog_out_channel_o, // 12-bit output code
    output reg [11:0] ao_readback_o // output value readback
);
// ------------------------------------------------------------
// cycle and sample enables
// ------------------------------------------------------------
reg [15:0] cyc_cnt_r;
reg [15:0] smp_cnt_r;
reg cyc_en_r;
reg smp_en_r;
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        cyc_cnt_r <= `DIOS_CNT_ZERO;
        smp_cnt_r <= `DIOS_CNT_ZERO;
        cyc_en_r <= 1'b0;
        smp_en_r <= 1'b0;
    end else begin
        cyc_en_r <= (cyc_cnt_r >= controller_cycle_setting_i);
        cyc_cnt_r <= (cyc_cnt_r >= controller_cycle_setting_i) ? `DIOS_CNT_ZERO :
                     cyc_cnt_r + `DIOS_CNT_ONE;
        smp_en_r <= (smp_cnt_r >= io_sample_time_setting_i);
        smp_cnt_r <= (smp_cnt_r >= io_sample_time_setting_i) ? `DIOS_CNT_ZERO :
                     smp_cnt_r + `DIOS_CNT_ONE;
    end
end
// ------------------------------------------------------------
// digital input conditioning (plain inputs and bidir inputs)
// ------------------------------------------------------------
function sel_src;
    input [15:0] bits;
    input [3:0] sel;
    begin
        sel_src = bits[sel];
    end
endfunction
// high active, pin sampled as is
wire [15:0] raw_in = {bidir_pin_i, digital_in_pin_i};
wire [15:0] sim_en = {bd_sim_en_i, di_sim_en_i};
wire [15:0] sim_val = {bd_sim_val_i, di_sim_val_i};
wire [15:0] deb_r;
genvar g;
generate
    for (g = 0; g < 16; g = g + 1) begin : g_deb
        reg last_r;
        reg bit_r;
        wire src = sim_en[g] ? sim_val[g] : raw_in[g];
        always @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                last_r <= 1'b0;
                bit_r <= 1'b0;
            end else if (cyc_en_r) begin
                last_r <= src;
                // one to two cycle delay
                // two equal samples one cycle apart, so a change shows after one to two cycles
                if (src == last_r) begin
                    bit_r <= last_r;
                end
            end
        end
        assign deb_r[g] = bit_r;
    end
endgenerate
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        di_true_o <= 8'h00;
        di_inv_o <= 8'hff;
        di_word_o <= 16'h0000;
        bd_in_true_o <= 8'h00;
        bd_in_inv_o <= 8'hff;
    end else if (smp_en_r) begin
        di_true_o <= deb_r[7:0];
        di_inv_o <= ~deb_r[7:0];
        // bidir in input mode reads like an input
        bd_in_true_o <= deb_r[15:8] & ~bd_dir_out_i;
        bd_in_inv_o <= ~(deb_r[15:8] & ~bd_dir_out_i);
        di_word_o <= {deb_r[15:8] & ~bd_dir_out_i, deb_r[7:0]};
    end
end
// ------------------------------------------------------------
// fast capture: bypasses debounce and sampling
// ------------------------------------------------------------
reg [5:0] fast_prev_r;
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        fast_prev_r <= 6'h00;
        bd_meas_val_o <= 6'h00;
        bd_meas_done_o <= 6'h00;
    end else begin
        fast_prev_r <= bidir_pin_i[5:0];
        // latch on edge at once
        // each channel freezes on its own capture, not on any other
        bd_meas_val_o <= (bd_meas_done_o & bd_meas_val_o) | (~bd_meas_done_o & bidir_pin_i[5:0]);
        bd_meas_done_o <= (bd_meas_done_o | (bd_meas_arm_i & ~bd_dir_out_i[5:0]
                          & (fast_prev_r ^ bidir_pin_i[5:0]))) & bd_meas_arm_i;
    end
end
// ------------------------------------------------------------
// digital outputs
// ------------------------------------------------------------
reg [3:0] do_nxt;
reg [7:0] bd_nxt;
integer k;
always @* begin
    for (k = 0; k < 4; k = k + 1) begin
        do_nxt[k] = sel_src(do_src_bits_i, do_src_sel_i[k*4 +: 4]) ^ do_invert_i[k];
    end
    for (k = 0; k < 8; k = k + 1) begin
        bd_nxt[k] = sel_src(do_src_bits_i, bd_src_sel_i[k*4 +: 4]) ^ bd_invert_i[k];
    end
end
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        digital_out_pin_o <= 4'h0;
        do_state_o <= 4'h0;
        do_word_o <= 16'h0000;
        bidir_pin_o <= 8'h00;
        bidir_pin_oe_o <= 8'h00;
    end else begin
        bidir_pin_oe_o <= bd_dir_out_i;
        if (smp_en_r) begin
            digital_out_pin_o <= do_nxt;
            bidir_pin_o <= bd_nxt & bd_dir_out_i;
            do_state_o <= do_nxt;
            do_word_o <= {4'h0, bd_nxt & bd_dir_out_i, do_nxt};
        end
    end
end
// ------------------------------------------------------------
// analog input path
// ------------------------------------------------------------
reg signed [15:0] ai_acc_r;
wire signed [13:0] ai_raw = ai_sim_en_i ? ai_sim_val_i : analog_in_channel_i;
wire signed [15:0] ai_off = {{2{ai_raw[13]}}, ai_raw} + {{2{ai_offset_i[13]}}, ai_offset_i};
wire signed [31:0] ai_prod = ai_off * $signed(ai_scale_i);
wire signed [15:0] ai_scl = ai_prod[23:8];
wire signed [15:0] ai_inv = ai_invert_i ? -ai_scl : ai_scl;
wire signed [15:0] ai_abs = (ai_abs_i && ai_inv[15]) ? -ai_inv : ai_inv;
wire signed [15:0] ai_diff = ai_abs - ai_acc_r;
wire signed [15:0] ai_step = ai_diff >>> ai_smooth_i;
wire signed [15:0] ai_new = ai_acc_r + ai_step;
wire signed [15:0] ai_dv = ai_new - {{2{ai_value_o[13]}}, ai_value_o};
wire [15:0] ai_mag = ai_dv[15] ? -ai_dv : ai_dv;
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        ai_acc_r <= 16'h0000;
        ai_value_o <= 14'h0000;
    end else if (ai_valid_i) begin
        ai_acc_r <= ai_new;
        if (!ai_enable_i) begin
            ai_value_o <= 14'h0000;
        end else if (ai_mag > {2'h0, analog_noise_suppress_setting_i}) begin
            ai_value_o <= ai_new[13:0];
        end
    end
end
// ------------------------------------------------------------
// analog output path
// ------------------------------------------------------------
reg signed [15:0] ao_acc_r;
wire signed [15:0] ao_in = {{2{ao_setpoint_i[13]}}, ao_setpoint_i};
wire signed [15:0] ao_abs = (ao_abs_i && ao_in[15]) ? -ao_in : ao_in;
wire signed [15:0] ao_inv = ao_invert_i ? -ao_abs : ao_abs;
wire signed [15:0] ao_step = (ao_inv - ao_acc_r) >>> ao_smooth_i;
wire signed [15:0] ao_dx = ao_acc_r - {{2{ao_x1_i[13]}}, ao_x1_i};
wire signed [31:0] ao_prod = ao_dx * $signed(ao_slope_i);
wire signed [15:0] ao_y = ao_prod[23:8] + {{2{ao_y1_i[13]}}, ao_y1_i};
wire [11:0] ao_code = ao_y[13:2];
always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
        ao_acc_r <= 16'h0000;
        analog_out_channel_o <= 12'h000;
        ao_readback_o <= 12'h000;
    end else if (smp_en_r) begin
        ao_acc_r <= ao_acc_r + ao_step;
        analog_out_channel_o <= ao_code;
        ao_readback_o <= ao_code;
    end
end
endmodule
`default_nettype wire

// ---- dios_field.sv ----
`timescale 1ns/1ps
`default_nettype none
module dios_field (
    input wire logic [7:0] sw_i, // switch levels
    input wire logic [7:0] open_i, // unwired inputs
    input wire logic [7:0] ext_i, // sensor levels
    input wire logic [7:0] drv_i, // device drive
    input wire logic [7:0] oe_i, // device enable
    output wire logic [7:0] di_o, // input pins
    output wire logic [7:0] bd_o // bidir wire
);
    assign di_o = sw_i & ~open_i;
    assign bd_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ---- dios_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dios_chk (
    input wire logic clk_i, // clock
    input wire logic reset_i, // reset
    input wire logic [7:0] digital_in_pin_i, // pins
    input wire logic [7:0] di_sim_en_i, // sim enable
    input wire logic [7:0] di_true_o, // inputs
    input wire logic [7:0] di_inv_o, // complement
    input wire logic [15:0] di_word_o, // word
    input wire logic [3:0] digital_out_pin_o, // outputs
    input wire logic [3:0] do_state_o, // state
    input wire logic [7:0] bidir_pin_i, // bidir level
    input wire logic [7:0] bidir_pin_oe_o, // drive enable
    input wire logic [7:0] bd_dir_out_i, // direction
    input wire logic [7:0] bd_in_true_o, // bidir inputs
    input wire logic [7:0] bd_in_inv_o, // complement
    input wire logic [5:0] bd_meas_arm_i, // arm
    input wire logic [5:0] bd_meas_done_o, // captured
    input wire logic [11:0] analog_out_channel_o, // code
    input wire logic [11:0] ao_readback_o // readback
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_armed_rise;
        bd_meas_arm_i[0] && !bd_dir_out_i[0] && !bd_meas_done_o[0] && $rose(bidir_pin_i[0]);
    endsequence
    sequence s_clean_rise;
        $rose(di_true_o[1]) && !di_sim_en_i[1];
    endsequence
    a_inv_pair: assert property (di_inv_o == ~di_true_o)
        else $error("inverted inputs differ");
    a_bd_inv_pair: assert property (bd_in_inv_o == ~bd_in_true_o)
        else $error("inverted bidir inputs differ");
    a_in_word: assert property (di_word_o == {bd_in_true_o, di_true_o})
        else $error("input word differs");
    a_state_back: assert property (do_state_o == digital_out_pin_o)
        else $error("output state differs");
    a_oe_follow: assert property (!$past(reset_i) |-> bidir_pin_oe_o == $past(bd_dir_out_i))
        else $error("drive enable wrong");
    // a rise needs the pin held high over the earlier samples
    a_deb_hold: assert property (s_clean_rise |-> $past(digital_in_pin_i[1], 2) && $past(digital_in_pin_i[1], 3))
        else $error("input passed without debounce");
    a_meas_fast: assert property (s_armed_rise |-> ##[1:3] bd_meas_done_o[0])
        else $error("capture too slow");
    a_meas_clear: assert property (!bd_meas_arm_i[0] |=> !bd_meas_done_o[0])
        else $error("capture not cleared");
    a_ao_back: assert property (ao_readback_o == analog_out_channel_o)
        else $error("analog readback differs");
endmodule
`default_nettype wire

// ---- dios_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module dios_top_test;
    logic clk_i = 0, reset_i = 1, p = 0;
    logic [15:0] controller_cycle_setting_i = '0, io_sample_time_setting_i = '0;
    logic [15:0] do_src_bits_i = '0, do_src_sel_i = '0, ai_scale_i = 16'h0100, ao_slope_i = 16'h0100;
    logic [7:0] di_sim_en_i = '0, di_sim_val_i = 8'h08, bd_dir_out_i = 8'hc0, bd_sim_en_i = '0;
    logic [7:0] bd_sim_val_i = '0, bd_invert_i = 8'h80, sw = '0, opn = '0, ext = '0;
    logic [31:0] bd_src_sel_i = '0;
    logic [3:0] do_invert_i = '0, ai_smooth_i = '0, ao_smooth_i = '0;
    logic [5:0] bd_meas_arm_i = '0;
    logic [13:0] analog_in_channel_i = '0, ai_offset_i = '0, analog_noise_suppress_setting_i = '0;
    logic [13:0] ai_sim_val_i = '0, ao_setpoint_i = 14'h0400, ao_x1_i = 14'h0100, ao_y1_i = 14'h0200;
    logic ai_valid_i = 0, ai_invert_i = 0, ai_abs_i = 0, ai_enable_i = 1, ai_sim_en_i = 0;
    logic ao_abs_i = 0, ao_invert_i = 0;
    wire [7:0] digital_in_pin_i, bidir_pin_i, di_true_o, di_inv_o, bidir_pin_o, bidir_pin_oe_o;
    wire [7:0] bd_in_true_o, bd_in_inv_o;
    wire [15:0] di_word_o, do_word_o;
    wire [3:0] digital_out_pin_o, do_state_o;
    wire [5:0] bd_meas_val_o, bd_meas_done_o;
    wire [13:0] ai_value_o;
    wire [11:0] analog_out_channel_o, ao_readback_o;
    int num_errors = 0, checks = 0, n = 0;
    // row: source bits, selects, inversion, expected pins
    logic [39:0] rows [4] = '{40'h00_0100_000f, 40'h84_21fa_505a, 40'h00_0032_10ff, 40'h00_0e32_100e};
    dios_top u_dut (.clk_i, .reset_i, .controller_cycle_setting_i, .io_sample_time_setting_i,
        .digital_in_pin_i, .di_sim_en_i, .di_sim_val_i, .di_true_o, .di_inv_o, .di_word_o,
        .do_src_bits_i, .do_src_sel_i, .do_invert_i, .digital_out_pin_o, .do_state_o, .do_word_o,
        .bidir_pin_i, .bidir_pin_o, .bidir_pin_oe_o, .bd_dir_out_i, .bd_sim_en_i, .bd_sim_val_i,
        .bd_src_sel_i, .bd_invert_i, .bd_in_true_o, .bd_in_inv_o, .bd_meas_arm_i, .bd_meas_val_o,
        .bd_meas_done_o, .analog_in_channel_i, .ai_valid_i, .ai_offset_i, .ai_scale_i, .ai_smooth_i,
        .analog_noise_suppress_setting_i, .ai_invert_i, .ai_abs_i, .ai_enable_i, .ai_sim_en_i,
        .ai_sim_val_i, .ai_value_o, .ao_setpoint_i, .ao_abs_i, .ao_invert_i, .ao_smooth_i, .ao_x1_i,
        .ao_y1_i, .ao_slope_i, .analog_out_channel_o, .ao_readback_o);
    dios_field u_field (.sw_i(sw), .open_i(opn), .ext_i(ext), .drv_i(bidir_pin_o),
        .oe_i(bidir_pin_oe_o), .di_o(digital_in_pin_i), .bd_o(bidir_pin_i));
    always #4 clk_i = ~clk_i;
    task tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task ai_pulse;
        ai_valid_i <= 1;
        tick(1);
        ai_valid_i <= 0;
        tick(3);
        @(negedge clk_i);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    initial begin
        tick(9);
        @(negedge clk_i);
        chk(di_inv_o, 8'hff);
        chk({di_true_o, do_state_o}, 12'h000);
        tick(1);
        reset_i <= 0;
        foreach (rows[r]) begin
            tick(1);
            {do_src_bits_i, do_src_sel_i, do_invert_i} <= rows[r][39:4];
            tick(3);
            @(negedge clk_i);
            chk(digital_out_pin_o, rows[r][3:0]);
            chk({do_state_o, do_word_o[3:0]}, {2{rows[r][3:0]}});
            chk({bidir_pin_o, do_word_o[11:4]}, {2{~rows[r][24], rows[r][24], 6'h00}});
        end
        tick(1);
        sw <= 8'h02;
        bd_meas_arm_i <= 6'h01;
        tick(1);
        sw <= 8'h00;
        tick(8);
        @(negedge clk_i);
        chk(di_true_o, 8'h00);
        tick(1);
        sw <= 8'h06;
        opn <= 8'h04;
        di_sim_en_i <= 8'h08;
        ext <= 8'h01;
        tick(10);
        @(negedge clk_i);
        chk(di_true_o[1], 1'b1);
        chk(di_true_o[2], 1'b0);
        chk(di_true_o[3], 1'b1);
        chk({di_inv_o, di_word_o[7:0]}, 16'hf50a);
        chk({di_word_o[8], bd_in_true_o[0]}, 2'h3);
        chk({bd_meas_done_o[0], bd_meas_val_o[0]}, 2'h3);
        tick(1);
        bd_meas_arm_i <= 6'h00;
        io_sample_time_setting_i <= 16'h0007;
        // a toggle of period two seen every eight clocks never changes
        for (int i = 0; i < 32; i++) begin
            tick(1);
            do_src_bits_i[0] <= ~do_src_bits_i[0];
            @(negedge clk_i);
            if (i > 9 && digital_out_pin_o[0] !== p) n = n + 1;
            p = digital_out_pin_o[0];
        end
        chk(n[15:0], 16'h0000);
        chk(bd_meas_done_o[0], 1'b0);
        tick(1);
        io_sample_time_setting_i <= '0;
        controller_cycle_setting_i <= 16'h0003;
        // cycle enables now fall every fourth clock; a pulse seen by one enable only is dropped
        tick(3);
        sw <= 8'h16;
        tick(3);
        sw <= 8'h06;
        tick(4);
        sw <= 8'h16;
        tick(4);
        @(negedge clk_i);
        chk(di_true_o[4], 1'b0);
        tick(5);
        @(negedge clk_i);
        chk(di_true_o[4], 1'b1);
        tick(1);
        io_sample_time_setting_i <= '0;
        analog_in_channel_i <= 14'h0100;
        ai_offset_i <= 14'h0010;
        ai_valid_i <= 1;
        tick(1);
        ai_valid_i <= 0;
        tick(3);
        @(negedge clk_i);
        chk(ai_value_o, 14'h0110);
        chk(analog_out_channel_o, 12'h140);
        tick(1);
        ai_offset_i <= '0;
        ai_invert_i <= 1;
        ai_valid_i <= 1;
        tick(1);
        ai_valid_i <= 0;
        tick(3);
        @(negedge clk_i);
        chk(ai_value_o, 14'h3f00);
        tick(1);
        ai_abs_i <= 1;
        ai_pulse;
        chk(ai_value_o, 14'h0100);
        tick(1);
        ai_abs_i <= 0;
        ai_invert_i <= 0;
        ai_sim_en_i <= 1;
        ai_sim_val_i <= 14'h0040;
        ai_pulse;
        chk(ai_value_o, 14'h0040);
        tick(1);
        analog_noise_suppress_setting_i <= 14'h0020;
        ai_sim_val_i <= 14'h0050;
        ai_pulse;
        chk(ai_value_o, 14'h0040);
        tick(1);
        ai_scale_i <= 16'h0200;
        ai_pulse;
        chk(ai_value_o, 14'h00a0);
        tick(1);
        ai_scale_i <= 16'h0100;
        ai_smooth_i <= 4'h1;
        ai_sim_val_i <= 14'h0020;
        ai_pulse;
        chk(ai_value_o, 14'h0060);
        tick(1);
        ai_enable_i <= 0;
        ai_pulse;
        chk(ai_value_o, 14'h0000);
        tick(1);
        ao_invert_i <= 1;
        tick(3);
        @(negedge clk_i);
        chk(analog_out_channel_o, 12'hf40);
        tick(1);
        ao_invert_i <= 0;
        ao_abs_i <= 1;
        ao_setpoint_i <= 14'h3c00;
        tick(3);
        @(negedge clk_i);
        chk(analog_out_channel_o, 12'h140);
        tick(1);
        ao_abs_i <= 0;
        ao_smooth_i <= 4'h1;
        ao_setpoint_i <= 14'h0000;
        tick(3);
        @(negedge clk_i);
        chk(analog_out_channel_o, 12'h080);
        end_of_test;
    end
endmodule
bind dios_top dios_chk u_chk (.clk_i, .reset_i, .digital_in_pin_i, .di_sim_en_i, .di_true_o,
    .di_inv_o, .di_word_o, .digital_out_pin_o, .do_state_o, .bidir_pin_i, .bidir_pin_oe_o,
    .bd_dir_out_i, .bd_in_true_o, .bd_in_inv_o, .bd_meas_arm_i, .bd_meas_done_o,
    .analog_out_channel_o, .ao_readback_o);
`default_nettype wire
